// ==== logic/isc_irq_ctrl.sv ====
// interrupt status and mask register with active-low request pin
// Summary of operation
// RULE_01: two-byte interrupt register at address 0x09
// RULE_02: status bits ignore writes, read live state
// RULE_03: mask bits [1:0] writable and read back
// RULE_04: request pin active low on enabled event
// RULE_05: writing one to bit 12 clears lost
// RULE_06: clear-lock bit keeps its written value
// RULE_07: lost bit latches until cleared by software
// RULE_08: bit 10 shows live sync state
// RULE_09: data timing error flag sets on violation
// RULE_10: sync timing error flag sets on violation
// RULE_11: bit 5 gives data error type
// RULE_12: bit 4 gives sync error type
// RULE_13: bit 3 shows multiplier lock
// RULE_14: data enable gates data errors onto pin
// RULE_15: sync enable gates sync errors onto pin
// RULE_16: reserved bits have no function, read zero
// RULE_17: pin is inverted OR of gated flags
// RULE_18: error flags and types hold until reset
`timescale 1ns/100ps
module isc_irq_ctrl
  import isc_pkg::*;
#(
  parameter int unsigned ADDR_W = ISC_ADDR_W
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [ISC_DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [ISC_DATA_W-1:0] REG_RDATA,
  output logic REG_HIT,
  input wire logic DATA_ERR_PULSE,
  input wire logic DATA_ERR_SETUP,
  input wire logic SYNC_ERR_PULSE,
  input wire logic SYNC_ERR_SETUP,
  input wire logic SYNC_LOCKED,
  input wire logic PLL_LOCKED_ASYNC,
  output logic IRQ_N
);

  // refused at elaboration: a narrower address cannot decode the register
  if (ADDR_W < ISC_ADDR_W) begin : g_addr_chk
    $error("isc_irq_ctrl: ADDR_W too narrow for the register address");
  end

  logic sel;
  logic wr_hit;
  logic data_en_r;
  logic sync_en_r;
  logic clr_lock_r;
  logic lock_lost_r;
  logic sync_prev_r;
  logic data_err_r;
  logic data_type_r;
  logic sync_err_r;
  logic sync_type_r;
  logic pll_meta_r;
  logic pll_lock_r;
  logic lost_event;
  logic irq_nxt;
  logic [ISC_DATA_W-1:0] rd_word;

  assign sel = (REG_ADDR == ADDR_W'(ISC_REG_ADDR)); // see RULE_01
  assign wr_hit = REG_WR && sel;

  // mask bits; status positions are not touched by writes
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      data_en_r <= ISC_RST_BIT;
      sync_en_r <= ISC_RST_BIT;
    end else if (wr_hit) begin
      data_en_r <= REG_WDATA[ISC_BIT_DATA_EN]; // see RULE_03
      sync_en_r <= REG_WDATA[ISC_BIT_SYNC_EN]; // see RULE_03
    end
  end

  // clear-lock control is a plain stored bit, never self-clearing
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      clr_lock_r <= ISC_RST_BIT;
    end else if (wr_hit) begin
      clr_lock_r <= REG_WDATA[ISC_BIT_CLR_LOCK]; // see RULE_06
    end
  end

  // a loss of lock is the falling edge of the live sync indication
  assign lost_event = sync_prev_r && !SYNC_LOCKED;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sync_prev_r <= ISC_RST_BIT;
    end else begin
      sync_prev_r <= SYNC_LOCKED;
    end
  end

  // the clear acts on the write itself, not on the stored level, so a held
  // one in bit 12 cannot mask a later loss; a loss in the clear cycle wins
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      lock_lost_r <= ISC_RST_BIT;
    end else if (lost_event) begin
      lock_lost_r <= 1'b1; // see RULE_07
    end else if (wr_hit && REG_WDATA[ISC_BIT_CLR_LOCK]) begin
      lock_lost_r <= 1'b0; // see RULE_05
    end
  end

  // data port checker: flag and type captured on the first violation
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      data_err_r <= ISC_RST_BIT;
      data_type_r <= ISC_TYPE_HOLD;
    end else if (DATA_ERR_PULSE && !data_err_r) begin
      data_err_r <= 1'b1; // see RULE_09
      data_type_r <= DATA_ERR_SETUP ? ISC_TYPE_SETUP : ISC_TYPE_HOLD; // see RULE_11
    end
  end // see RULE_18

  // sync pulse checker: same capture-and-hold policy
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sync_err_r <= ISC_RST_BIT;
      sync_type_r <= ISC_TYPE_HOLD;
    end else if (SYNC_ERR_PULSE && !sync_err_r) begin
      sync_err_r <= 1'b1; // see RULE_10
      sync_type_r <= SYNC_ERR_SETUP ? ISC_TYPE_SETUP : ISC_TYPE_HOLD; // see RULE_12
    end
  end // see RULE_18

  // multiplier lock comes from the analog side, so two flops first
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pll_meta_r <= ISC_RST_BIT;
      pll_lock_r <= ISC_RST_BIT;
    end else begin
      pll_meta_r <= PLL_LOCKED_ASYNC;
      pll_lock_r <= pll_meta_r; // see RULE_13
    end
  end

  // readback word; reserved positions stay zero
  always_comb begin
    rd_word = ISC_RD_ZERO; // see RULE_16
    rd_word[ISC_BIT_CLR_LOCK] = clr_lock_r;
    rd_word[ISC_BIT_LOCK_LOST] = lock_lost_r;
    rd_word[ISC_BIT_LOCK_LIVE] = SYNC_LOCKED; // see RULE_08
    rd_word[ISC_BIT_DATA_ERR] = data_err_r; // see RULE_02
    rd_word[ISC_BIT_SYNC_ERR] = sync_err_r;
    rd_word[ISC_BIT_DATA_TYPE] = data_type_r;
    rd_word[ISC_BIT_SYNC_TYPE] = sync_type_r;
    rd_word[ISC_BIT_PLL_LOCK] = pll_lock_r;
    rd_word[ISC_BIT_DATA_EN] = data_en_r;
    rd_word[ISC_BIT_SYNC_EN] = sync_en_r;
  end

  // read data is registered so the serial shifter sees a stable word;
  // other addresses read zero so the port can OR several register files
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= ISC_RD_ZERO;
      REG_HIT <= ISC_RST_BIT;
    end else if (REG_RD) begin
      REG_RDATA <= sel ? rd_word : ISC_RD_ZERO; // see RULE_02
      REG_HIT <= sel;
    end
  end

  assign irq_nxt = !((data_err_r && data_en_r) || (sync_err_r && sync_en_r)); // see RULE_17

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      IRQ_N <= ISC_RST_IRQ_N;
    end else begin
      IRQ_N <= irq_nxt; // see RULE_04 see RULE_14 see RULE_15
    end
  end

endmodule // isc_irq_ctrl

// ==== include/isc_pkg.sv ====
// constants for the interrupt status and control register
package isc_pkg;
  localparam int unsigned ISC_ADDR_W = 5;
  localparam int unsigned ISC_DATA_W = 16;
  localparam logic [ISC_ADDR_W-1:0] ISC_REG_ADDR = 5'h09;
  // field positions
  localparam int unsigned ISC_BIT_CLR_LOCK = 12;
  localparam int unsigned ISC_BIT_LOCK_LOST = 11;
  localparam int unsigned ISC_BIT_LOCK_LIVE = 10;
  localparam int unsigned ISC_BIT_DATA_ERR = 7;
  localparam int unsigned ISC_BIT_SYNC_ERR = 6;
  localparam int unsigned ISC_BIT_DATA_TYPE = 5;
  localparam int unsigned ISC_BIT_SYNC_TYPE = 4;
  localparam int unsigned ISC_BIT_PLL_LOCK = 3;
  localparam int unsigned ISC_BIT_DATA_EN = 1;
  localparam int unsigned ISC_BIT_SYNC_EN = 0;
  // reset values
  localparam logic ISC_RST_BIT = 1'b0;
  localparam logic ISC_RST_IRQ_N = 1'b1;
  localparam logic [ISC_DATA_W-1:0] ISC_RD_ZERO = 16'h0000;
  // error type encoding
  localparam logic ISC_TYPE_HOLD = 1'b0;
  localparam logic ISC_TYPE_SETUP = 1'b1;
endpackage

// ==== sim/isc_irq_ctrl_checker.sv ====
// concurrent checks on the interrupt status and control ports
`timescale 1ns/100ps
module isc_irq_ctrl_checker
  import isc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic REG_HIT,
  input wire logic IRQ_N,
  input wire logic SYNC_LOCKED,
  input wire logic [ISC_ADDR_W-1:0] REG_ADDR,
  input wire logic [ISC_DATA_W-1:0] REG_WDATA,
  input wire logic [ISC_DATA_W-1:0] REG_RDATA
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic hit;
  assign hit = REG_ADDR == ISC_REG_ADDR;
  read_hit_a: assert property (REG_RD && hit |=> REG_HIT)
    else $error("read of the interrupt register not flagged");
  miss_zero_a: assert property (REG_RD && !hit |=>
    REG_RDATA == ISC_RD_ZERO && !REG_HIT)
    else $error("read of another address not zero");
  reserved_zero_a: assert property (
    REG_RDATA[15:13] == 3'h0 && REG_RDATA[9:8] == 2'h0 && !REG_RDATA[2])
    else $error("reserved bit reads one");
  read_hold_a: assert property (!REG_RD |=>
    $stable(REG_RDATA) && $stable(REG_HIT))
    else $error("read word changed without a read");
  live_sync_a: assert property (REG_RD && hit |=>
    REG_RDATA[10] == $past(SYNC_LOCKED))
    else $error("live sync bit wrong");
  // a later violation must not rewrite the first type seen
  flag_sticky_a: assert property (REG_RD && hit && REG_RDATA[7] |=>
    REG_RDATA[7] && REG_RDATA[5] == $past(REG_RDATA[5]))
    else $error("data error flag or type not held");
  mask_off_a: assert property (REG_WR && hit && REG_WDATA[1:0] == 2'h0
    ##1 !REG_WR |=> IRQ_N)
    else $error("request pin low with both enables off");
  lock_clear_a: assert property (REG_WR && hit && REG_WDATA[12] && SYNC_LOCKED
    && $past(SYNC_LOCKED) ##1 REG_RD && hit && SYNC_LOCKED
    |=> !REG_RDATA[11] && REG_RDATA[12])
    else $error("lost bit not cleared or clear bit not kept");
  cover property (REG_RD && hit ##1 REG_RDATA[11]);
  cover property ($fell(IRQ_N));
  cover property ($rose(IRQ_N));
endmodule // isc_irq_ctrl_checker

// ==== sim/isc_irq_ctrl_tb.sv ====
// self-checking bench for the interrupt status and control register
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module isc_irq_ctrl_tb;
  import isc_pkg::*;
  logic CORE_CLK = 1'b0, SYS_RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, REG_HIT, IRQ_N;
  logic DATA_ERR_PULSE = 1'b0, DATA_ERR_SETUP = 1'b0, SYNC_ERR_PULSE = 1'b0;
  logic SYNC_ERR_SETUP = 1'b0, SYNC_LOCKED = 1'b0, PLL_LOCKED_ASYNC = 1'b0;
  logic [ISC_ADDR_W-1:0] REG_ADDR = ISC_REG_ADDR;
  logic [ISC_DATA_W-1:0] REG_WDATA = 16'h0000, REG_RDATA;
  int miscompares = 0, comparisons = 0;
  isc_irq_ctrl isc_irq_ctrl_inst (
    .CORE_CLK(CORE_CLK),
    .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .REG_HIT(REG_HIT),
    .DATA_ERR_PULSE(DATA_ERR_PULSE),
    .DATA_ERR_SETUP(DATA_ERR_SETUP),
    .SYNC_ERR_PULSE(SYNC_ERR_PULSE),
    .SYNC_ERR_SETUP(SYNC_ERR_SETUP),
    .SYNC_LOCKED(SYNC_LOCKED),
    .PLL_LOCKED_ASYNC(PLL_LOCKED_ASYNC),
    .IRQ_N(IRQ_N)
  );
  initial forever #2.5 CORE_CLK = ~CORE_CLK;
  task automatic w(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  // the leading wait keeps back-to-back writes from touching the strobe twice in one step
  task automatic wr(input logic [15:0] d);
    w(1);
    REG_WDATA = d;
    REG_WR = 1'b1;
    w(1);
    REG_WR = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic h);
    REG_ADDR = a;
    REG_RD = 1'b1;
    w(1);
    REG_RD = 1'b0;
    REG_ADDR = ISC_REG_ADDR;
    `CHK("read word", e, REG_RDATA)
    `CHK("read hit", h, REG_HIT)
    w(1);
  endtask
  task automatic pe(input logic dp, ds, sp, ss);
    DATA_ERR_PULSE = dp;
    DATA_ERR_SETUP = ds;
    SYNC_ERR_PULSE = sp;
    SYNC_ERR_SETUP = ss;
    w(1);
    DATA_ERR_PULSE = 1'b0;
    SYNC_ERR_PULSE = 1'b0;
  endtask
  task automatic t_reset();
    rd(ISC_REG_ADDR, 16'h0000, 1'b1);
    rd(5'h08, 16'h0000, 1'b0);
  endtask
  task automatic t_mask();
    wr(16'hffff);
    rd(ISC_REG_ADDR, 16'h1003, 1'b1);
    wr(16'h0000);
    rd(ISC_REG_ADDR, 16'h0000, 1'b1);
  endtask
  task automatic t_sync();
    SYNC_LOCKED = 1'b1;
    PLL_LOCKED_ASYNC = 1'b1;
    w(3);
    rd(ISC_REG_ADDR, 16'h0408, 1'b1);
    SYNC_LOCKED = 1'b0;
    // the lost bit latches on the first edge that samples the low
    w(1);
    rd(ISC_REG_ADDR, 16'h0808, 1'b1);
    SYNC_LOCKED = 1'b1;
    w(3);
    rd(ISC_REG_ADDR, 16'h0c08, 1'b1);
    wr(16'h1000);
    rd(ISC_REG_ADDR, 16'h1408, 1'b1);
  endtask
  task automatic t_err();
    wr(16'h0000);
    pe(1'b1, 1'b1, 1'b1, 1'b0);
    w(3);
    `CHK("irq masked", 1'b1, IRQ_N)
    rd(ISC_REG_ADDR, 16'h04e8, 1'b1);
    pe(1'b1, 1'b0, 1'b1, 1'b1);
    rd(ISC_REG_ADDR, 16'h04e8, 1'b1);
    for (int i = 2; i >= 0; i--) begin
      wr(16'(i));
      w(3);
      `CHK("irq pin", i == 0, IRQ_N)
    end
  endtask
  // mid-run reset, then one source at a time so a swapped enable shows up
  task automatic t_gate();
    wr(16'h0003);
    w(3);
    SYS_RST = 1'b1;
    w(2);
    `CHK("irq in reset", 1'b1, IRQ_N)
    SYS_RST = 1'b0;
    rd(ISC_REG_ADDR, 16'h0400, 1'b1);
    pe(1'b1, 1'b0, 1'b0, 1'b0);
    wr(16'h0001);
    w(3);
    `CHK("irq sync enable only", 1'b1, IRQ_N)
    pe(1'b0, 1'b0, 1'b1, 1'b1);
    w(3);
    `CHK("irq sync error", 1'b0, IRQ_N)
    wr(16'h0002);
    w(3);
    `CHK("irq data enable only", 1'b0, IRQ_N)
    rd(ISC_REG_ADDR, 16'h04da, 1'b1);
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    w(5);
    SYS_RST = 1'b0;
    t_reset();
    t_mask();
    t_sync();
    t_err();
    t_gate();
    finish_test();
  end
  // the whole sequence needs about 86 cycles
  initial begin
    repeat (4000) @(posedge CORE_CLK);
    miscompares++;
    finish_test();
  end
endmodule // isc_irq_ctrl_tb
bind isc_irq_ctrl isc_irq_ctrl_checker isc_irq_ctrl_checker_inst (
  .CORE_CLK(CORE_CLK),
  .SYS_RST(SYS_RST),
  .REG_WR(REG_WR),
  .REG_RD(REG_RD),
  .REG_HIT(REG_HIT),
  .IRQ_N(IRQ_N),
  .SYNC_LOCKED(SYNC_LOCKED),
  .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA)
);
